// File: shared/ccu_pkg.sv
// shared constants for one counter array compare/capture unit
package ccu_pkg;

  localparam int unsigned ADDR_W   = 4;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned TIMER_W  = 16;

  // register byte addresses
  localparam logic [3:0] OFS_MODE_SELECT = 4'h0;
  localparam logic [3:0] OFS_COMPARE_LOW = 4'h4;
  localparam logic [3:0] OFS_COMPARE_HIGH = 4'h8;
  localparam logic [3:0] OFS_UNIT_STATUS = 4'hc;

  // module_mode_select field positions
  localparam int unsigned BIT_EVENT_IRQ_EN   = 0;
  localparam int unsigned BIT_PWM_OUT_EN     = 1;
  localparam int unsigned BIT_MATCH_TOGGLE   = 2;
  localparam int unsigned BIT_MATCH_FLAG_EN  = 3;
  localparam int unsigned BIT_FALL_CAPTURE   = 4;
  localparam int unsigned BIT_RISE_CAPTURE   = 5;
  localparam int unsigned BIT_COMPARATOR_EN  = 6;
  localparam int unsigned MODE_STORED_W      = 7;

  // unit_status field positions
  localparam int unsigned BIT_STAT_EVENT_FLAG = 0;
  localparam int unsigned BIT_STAT_PIN_OUT    = 1;
  localparam int unsigned BIT_STAT_PIN_OE     = 2;
  localparam int unsigned BIT_STAT_PIN_LEVEL  = 3;

  // values after reset
  localparam logic [6:0] RST_MODE_SELECT = 7'h00;
  localparam logic [7:0] RST_COMPARE     = 8'h00;
  localparam logic [7:0] RST_READ_DATA   = 8'h00;

  localparam logic [7:0] TIMER_LOW_WRAP = 8'h00;
  localparam int unsigned WATCHDOG_UNIT = 4;

  typedef enum logic [2:0] {
    mode_idle,
    mode_capture,
    mode_soft_timer,
    mode_hs_output,
    mode_pwm
  } unit_mode_t;

endpackage

// File: shared/pin_edge_if.sv
// pin level and edge pulses between sampler and unit core
`timescale 1ns/1ps
interface pin_edge_if;
  logic pin_level;
  logic rise;
  logic fall;

  modport sampler (input pin_level, output rise, output fall);
  modport core    (output pin_level, input rise, input fall);
endinterface

// File: src/pin_edge_sampler.sv
// edge detector on the unit's sampled pin
`timescale 1ns/1ps
module pin_edge_sampler (
  input  wire logic   clk,
  input  wire logic   reset,
  pin_edge_if.sampler edges
);

  logic prev_ff;
  logic seen_ff;

  always_ff @(posedge clk) begin
    if (reset) begin
      prev_ff <= 1'b0;
      seen_ff <= 1'b0;
    end else begin
      prev_ff <= edges.pin_level;
      seen_ff <= 1'b1;
    end
  end

  // no edge reported until a first level is known
  assign edges.rise = seen_ff && edges.pin_level && !prev_ff;
  assign edges.fall = seen_ff && !edges.pin_level && prev_ff;

endmodule

// File: src/compare_capture_unit.sv
// one compare/capture/pwm unit of the counter array, watchdog on unit 4
`timescale 1ns/1ps
// Contract
// - either edge bit enables capture, polarity chosen
// - pin sampled, valid edge triggers capture
// - capture copies timer pair, sets event flag
// - interrupt only when flag and enable set
// - comparator plus match: equality sets event flag
// - toggle added: pin inverts on each match
// - pwm needs pwm, comparator, others clear
// - pwm pin low below compare, else high
// - low byte wrap reloads active from reload
// - shared timer, duty per unit compare
// - only unit 4 has watchdog
// - watchdog armed: compare mode plus arm bit
// - armed and timer match gives internal reset
// - internal reset never drives external pin
// - clearing arm bit prevents reset, setting rearms
module compare_capture_unit #(
  parameter int unsigned UNIT_INDEX = 0
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [7:0]  reg_rdata,
  input  wire logic [15:0] array_timer,
  input  wire logic        timer_step,
  input  wire logic        watchdog_arm_bit,
  input  wire logic        module_pin_in,
  output logic             module_pin_out,
  output logic             module_pin_oe,
  output logic             event_irq,
  output logic             watchdog_reset
);

  logic [6:0]  mode_ff;
  logic [7:0]  compare_low_ff;
  logic [7:0]  compare_high_ff;
  logic        module_event_flag_ff;
  logic        pin_out_ff;
  logic        pin_oe_ff;
  logic        irq_ff;
  logic        wdt_reset_ff;
  logic [7:0]  rdata_ff;

  logic                 comparator_enable;
  logic                 rise_capture_enable;
  logic                 fall_capture_enable;
  logic                 match_flag_enable;
  logic                 match_toggle_enable;
  logic                 pwm_output_enable;
  logic                 event_interrupt_enable;
  ccu_pkg::unit_mode_t  unit_mode;
  logic                 timer_match;
  logic                 capture_hit;
  logic                 compare_hit;
  logic                 low_wrap;
  logic                 watchdog_armed;
  logic                 wr_mode;
  logic                 wr_low;
  logic                 wr_high;
  logic                 wr_status;
  logic [7:0]           status_view;
  logic [7:0]           nxt_rdata;

  pin_edge_if edges ();

  assign edges.pin_level = module_pin_in;

  pin_edge_sampler u_sampler (
    .clk   (clk),
    .reset (reset),
    .edges (edges)
  );

  assign comparator_enable      = mode_ff[ccu_pkg::BIT_COMPARATOR_EN];
  assign rise_capture_enable    = mode_ff[ccu_pkg::BIT_RISE_CAPTURE];
  assign fall_capture_enable    = mode_ff[ccu_pkg::BIT_FALL_CAPTURE];
  assign match_flag_enable      = mode_ff[ccu_pkg::BIT_MATCH_FLAG_EN];
  assign match_toggle_enable    = mode_ff[ccu_pkg::BIT_MATCH_TOGGLE];
  assign pwm_output_enable      = mode_ff[ccu_pkg::BIT_PWM_OUT_EN];
  assign event_interrupt_enable = mode_ff[ccu_pkg::BIT_EVENT_IRQ_EN];

  // mode decode; pwm only with comparator set and every other function bit clear
  always_comb begin
    if (pwm_output_enable && comparator_enable && !rise_capture_enable
        && !fall_capture_enable && !match_flag_enable && !match_toggle_enable
        && !event_interrupt_enable) begin
      unit_mode = ccu_pkg::mode_pwm;
    end else if (rise_capture_enable || fall_capture_enable) begin
      unit_mode = ccu_pkg::mode_capture;
    end else if (comparator_enable && match_flag_enable && match_toggle_enable) begin
      unit_mode = ccu_pkg::mode_hs_output;
    end else if (comparator_enable && match_flag_enable) begin
      unit_mode = ccu_pkg::mode_soft_timer;
    end else begin
      unit_mode = ccu_pkg::mode_idle;
    end
  end

  assign timer_match = timer_step
                       && (array_timer == {compare_high_ff, compare_low_ff});
  assign low_wrap = timer_step && (array_timer[7:0] == ccu_pkg::TIMER_LOW_WRAP);

  // polarity select on the sampled pin
  assign capture_hit = (unit_mode == ccu_pkg::mode_capture)
                       && ((rise_capture_enable && edges.rise)
                           || (fall_capture_enable && edges.fall));

  assign compare_hit = timer_match && ((unit_mode == ccu_pkg::mode_soft_timer)
                                       || (unit_mode == ccu_pkg::mode_hs_output));

  // watchdog exists only in unit 4
  generate
    if (UNIT_INDEX == ccu_pkg::WATCHDOG_UNIT) begin : g_watchdog
      assign watchdog_armed = watchdog_arm_bit && comparator_enable
                              && match_flag_enable;
    end else begin : g_no_watchdog
      assign watchdog_armed = 1'b0;
    end
  endgenerate

  assign wr_mode   = reg_write && (reg_addr == ccu_pkg::OFS_MODE_SELECT);
  assign wr_low    = reg_write && (reg_addr == ccu_pkg::OFS_COMPARE_LOW);
  assign wr_high   = reg_write && (reg_addr == ccu_pkg::OFS_COMPARE_HIGH);
  assign wr_status = reg_write && (reg_addr == ccu_pkg::OFS_UNIT_STATUS);

  // mode register; reserved bit 7 is not stored
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_ff <= ccu_pkg::RST_MODE_SELECT;
    end else if (wr_mode) begin
      mode_ff <= reg_wdata[6:0];
    end
  end

  // compare pair: capture load wins over a software write
  always_ff @(posedge clk) begin
    if (reset) begin
      compare_low_ff  <= ccu_pkg::RST_COMPARE;
      compare_high_ff <= ccu_pkg::RST_COMPARE;
    end else if (capture_hit) begin
      compare_low_ff  <= array_timer[7:0];
      compare_high_ff <= array_timer[15:8];
    end else if ((unit_mode == ccu_pkg::mode_pwm) && low_wrap) begin
      compare_low_ff  <= compare_high_ff;
      if (wr_high) begin
        compare_high_ff <= reg_wdata;
      end
    end else begin
      if (wr_low) begin
        compare_low_ff <= reg_wdata;
      end
      if (wr_high) begin
        compare_high_ff <= reg_wdata;
      end
    end
  end

  // event flag: set wins over software clear
  always_ff @(posedge clk) begin
    if (reset) begin
      module_event_flag_ff <= 1'b0;
    end else if (capture_hit || compare_hit) begin
      module_event_flag_ff <= 1'b1;
    end else if (wr_status && !reg_wdata[ccu_pkg::BIT_STAT_EVENT_FLAG]) begin
      module_event_flag_ff <= 1'b0;
    end
  end

  // pin drive for toggle and pwm modes
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_out_ff <= 1'b0;
      pin_oe_ff  <= 1'b0;
    end else begin
      case (unit_mode)
        ccu_pkg::mode_hs_output: begin
          pin_oe_ff <= 1'b1;
          if (timer_match) begin
            pin_out_ff <= !pin_out_ff;
          end
        end
        ccu_pkg::mode_pwm: begin
          pin_oe_ff  <= 1'b1;
          // shared timer low byte against this unit's own duty byte
          pin_out_ff <= (array_timer[7:0] >= compare_low_ff);
        end
        default: begin
          pin_oe_ff <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= module_event_flag_ff && event_interrupt_enable;
    end
  end

  // internal reset pulse, separate from the external reset pin
  always_ff @(posedge clk) begin
    if (reset) begin
      wdt_reset_ff <= 1'b0;
    end else begin
      wdt_reset_ff <= watchdog_armed && timer_match;
    end
  end

  always_comb begin
    status_view = 8'h00;
    status_view[ccu_pkg::BIT_STAT_EVENT_FLAG] = module_event_flag_ff;
    status_view[ccu_pkg::BIT_STAT_PIN_OUT]    = pin_out_ff;
    status_view[ccu_pkg::BIT_STAT_PIN_OE]     = pin_oe_ff;
    status_view[ccu_pkg::BIT_STAT_PIN_LEVEL]  = module_pin_in;
  end

  // read data valid only in the cycle after the strobe
  always_comb begin
    nxt_rdata = ccu_pkg::RST_READ_DATA;
    if (reg_read) begin
      case (reg_addr)
        ccu_pkg::OFS_MODE_SELECT:  nxt_rdata = {1'b0, mode_ff};
        ccu_pkg::OFS_COMPARE_LOW:  nxt_rdata = compare_low_ff;
        ccu_pkg::OFS_COMPARE_HIGH: nxt_rdata = compare_high_ff;
        ccu_pkg::OFS_UNIT_STATUS:  nxt_rdata = status_view;
        default:                   nxt_rdata = ccu_pkg::RST_READ_DATA;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_ff <= ccu_pkg::RST_READ_DATA;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata      = rdata_ff;
  assign module_pin_out = pin_out_ff;
  assign module_pin_oe  = pin_oe_ff;
  assign event_irq      = irq_ff;
  assign watchdog_reset = wdt_reset_ff;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  logic past_valid_ff;

  always_ff @(posedge clk) begin
    if (reset) begin
      past_valid_ff <= 1'b0;
    end else begin
      past_valid_ff <= 1'b1;
    end
  end

  sequence seq_rise_capture;
    (unit_mode == ccu_pkg::mode_capture) && rise_capture_enable && edges.rise;
  endsequence

  sequence seq_pwm_wrap;
    (unit_mode == ccu_pkg::mode_pwm) && low_wrap && !reset;
  endsequence

  sequence seq_fall_only_rise;
    (unit_mode == ccu_pkg::mode_capture) && !rise_capture_enable
      && !module_event_flag_ff && edges.rise && !wr_status;
  endsequence

  sequence seq_fall_capture;
    (unit_mode == ccu_pkg::mode_capture) && fall_capture_enable && edges.fall;
  endsequence

  a_capture_load: assert property (
    seq_rise_capture |=> ({compare_high_ff, compare_low_ff} == $past(array_timer))
                         && module_event_flag_ff)
    else $error("capture did not load timer pair and flag");

  a_fall_only_ignores: assert property (
    seq_fall_only_rise |=> !module_event_flag_ff)
    else $error("rising edge captured while only falling enabled");

  a_irq_gated: assert property (
    event_irq |-> $past(module_event_flag_ff) && $past(event_interrupt_enable))
    else $error("interrupt request without flag and enable");

  a_fall_capture: assert property (
    seq_fall_capture |=> ({compare_high_ff, compare_low_ff} == $past(array_timer))
                         && module_event_flag_ff)
    else $error("falling edge did not load timer pair and flag");

  a_irq_follows: assert property (
    (module_event_flag_ff && event_interrupt_enable) |=> event_irq)
    else $error("flag and enable gave no interrupt request");

  a_match_sets_flag: assert property (
    (timer_match && comparator_enable && match_flag_enable
     && (unit_mode != ccu_pkg::mode_capture)) |=> module_event_flag_ff)
    else $error("compare match did not set event flag");

  a_toggle_on_match: assert property (
    ((unit_mode == ccu_pkg::mode_hs_output) ##1
     (unit_mode == ccu_pkg::mode_hs_output) && timer_match)
    |=> module_pin_oe && (module_pin_out != $past(module_pin_out)))
    else $error("high speed output did not toggle on match");

  a_pwm_level: assert property (
    (unit_mode == ccu_pkg::mode_pwm)
    |=> module_pin_out == ($past(array_timer[7:0]) >= $past(compare_low_ff)))
    else $error("pwm pin level does not follow duty compare");

  a_pwm_reload: assert property (
    seq_pwm_wrap |=> compare_low_ff == $past(compare_high_ff))
    else $error("pwm compare not reloaded on low byte wrap");

  a_wdt_fires: assert property (
    (watchdog_armed && timer_match)
    |=> watchdog_reset ##1 (!watchdog_reset || $past(watchdog_armed && timer_match)))
    else $error("armed watchdog match gave no single reset pulse");

  a_wdt_disarmed: assert property (
    (!watchdog_arm_bit || (UNIT_INDEX != ccu_pkg::WATCHDOG_UNIT))
    |=> !watchdog_reset)
    else $error("watchdog reset while not armed");

  a_reset_idle: assert property (
    (past_valid_ff && $past(reset)) || $rose(past_valid_ff)
    |-> (mode_ff == ccu_pkg::RST_MODE_SELECT) && !module_pin_oe)
    else $error("unit not idle after reset");

endmodule

// File: testbench/pin_model.sv
// far side of the unit pin: drives its own level while the unit is not driving
`timescale 1ns/1ps
module pin_model (
  input  wire logic drive_level,
  input  wire logic module_pin_out,
  input  wire logic module_pin_oe,
  output logic      module_pin_in
);
  // unit drive wins over the far side, so the pin read back follows the toggle
  assign module_pin_in = module_pin_oe ? module_pin_out : drive_level;
endmodule

// File: testbench/tb_top.sv
// self-checking bench for two compare/capture units, watchdog on unit 4
`timescale 1ns/1ps
module tb_top;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic [15:0] array_timer = 16'h0000;
  logic        timer_step = 1'b0;
  logic        watchdog_arm_bit = 1'b0;
  logic        drive_level = 1'b0;
  logic [7:0]  reg_rdata;
  logic        module_pin_in;
  logic        module_pin_out;
  logic        module_pin_oe;
  logic        event_irq;
  logic        watchdog_reset;
  logic        wd_plain;
  logic        wd_plain_seen = 1'b0;
  logic        rd_d = 1'b0;
  logic [15:0] exp_q[$];
  logic [7:0]  qm, qe, mode;
  logic [15:0] p, t1, t2, e16;
  logic        last;
  int          fail_count = 0;
  int          tests_run = 0;

  always #5 clk = ~clk;

  compare_capture_unit #(.UNIT_INDEX(4)) DUT (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .array_timer(array_timer), .timer_step(timer_step),
    .watchdog_arm_bit(watchdog_arm_bit), .module_pin_in(module_pin_in),
    .module_pin_out(module_pin_out), .module_pin_oe(module_pin_oe),
    .event_irq(event_irq), .watchdog_reset(watchdog_reset));

  // unit without watchdog sees the same traffic
  compare_capture_unit #(.UNIT_INDEX(0)) DUT_plain (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(),
    .array_timer(array_timer), .timer_step(timer_step),
    .watchdog_arm_bit(watchdog_arm_bit), .module_pin_in(module_pin_in),
    .module_pin_out(), .module_pin_oe(), .event_irq(), .watchdog_reset(wd_plain));

  pin_model far_side (
    .drive_level(drive_level), .module_pin_out(module_pin_out),
    .module_pin_oe(module_pin_oe), .module_pin_in(module_pin_in));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    exp_q.push_back({m, e});
    @(posedge clk);
    reg_read <= 1'b0;
  endtask

  task automatic tick(input logic [15:0] v);
    @(posedge clk);
    array_timer <= v;
    timer_step  <= 1'b1;
    @(posedge clk);
    timer_step  <= 1'b0;
    #1;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic endt(input string s);
    $display("test %s done", s);
  endtask

  // read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    rd_d <= reg_read;
    if (rd_d) begin
      if (exp_q.size() == 0) begin
        check(8'hee, 8'h00);
      end else begin
        {qm, qe} = exp_q.pop_front();
        check(reg_rdata & qm, qe);
      end
    end
    if (wd_plain === 1'b1) wd_plain_seen <= 1'b1;
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    results;
  end

  initial begin
    void'($urandom(25486));
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    rd(ccu_pkg::OFS_MODE_SELECT, 8'h00, 8'hff);
    rd(ccu_pkg::OFS_COMPARE_LOW, 8'h00, 8'hff);
    rd(ccu_pkg::OFS_COMPARE_HIGH, 8'h00, 8'hff);
    rd(ccu_pkg::OFS_UNIT_STATUS, 8'h00, 8'h07);
    rd(4'h2, 8'h00, 8'hff);
    check({7'h00, module_pin_oe}, 8'h00);
    p = 16'($urandom);
    wr(ccu_pkg::OFS_COMPARE_LOW, p[7:0]);
    wr(ccu_pkg::OFS_COMPARE_HIGH, p[15:8]);
    wr(4'h2, 8'h5a);
    rd(ccu_pkg::OFS_COMPARE_LOW, p[7:0], 8'hff);
    rd(ccu_pkg::OFS_COMPARE_HIGH, p[15:8], 8'hff);
    wr(ccu_pkg::OFS_MODE_SELECT, 8'h7f);
    rd(ccu_pkg::OFS_MODE_SELECT, 8'h7f, 8'h7f);
    endt("registers");
    for (int i = 0; i < 3; i++) begin
      mode = (i == 0) ? 8'h21 : (i == 1) ? 8'h10 : 8'h31;
      wr(ccu_pkg::OFS_MODE_SELECT, mode);
      wr(ccu_pkg::OFS_COMPARE_LOW, 8'h00);
      wr(ccu_pkg::OFS_COMPARE_HIGH, 8'h00);
      t1 = 16'($urandom);
      t2 = 16'($urandom);
      @(posedge clk);
      array_timer <= t1;
      drive_level <= 1'b1;
      idle(3);
      @(posedge clk);
      array_timer <= t2;
      drive_level <= 1'b0;
      idle(4);
      e16 = (i == 0) ? t1 : t2;
      rd(ccu_pkg::OFS_COMPARE_LOW, e16[7:0], 8'hff);
      rd(ccu_pkg::OFS_COMPARE_HIGH, e16[15:8], 8'hff);
      rd(ccu_pkg::OFS_UNIT_STATUS, 8'h01, 8'h01);
      check({7'h00, event_irq}, {7'h00, mode[0]});
      wr(ccu_pkg::OFS_UNIT_STATUS, 8'h00);
      rd(ccu_pkg::OFS_UNIT_STATUS, 8'h00, 8'h01);
    end
    endt("capture");
    p = 16'($urandom);
    wr(ccu_pkg::OFS_MODE_SELECT, 8'h48);
    wr(ccu_pkg::OFS_COMPARE_LOW, p[7:0]);
    wr(ccu_pkg::OFS_COMPARE_HIGH, p[15:8]);
    tick(p - 16'h0001);
    rd(ccu_pkg::OFS_UNIT_STATUS, 8'h00, 8'h01);
    tick(p);
    rd(ccu_pkg::OFS_UNIT_STATUS, 8'h01, 8'h01);
    wr(ccu_pkg::OFS_UNIT_STATUS, 8'h00);
    endt("soft timer");
    wr(ccu_pkg::OFS_MODE_SELECT, 8'h4c);
    idle(2);
    check({7'h00, module_pin_oe}, 8'h01);
    for (int k = 0; k < 3; k++) begin
      last = module_pin_out;
      tick((k == 2) ? p + 16'h0001 : p);
      check({7'h00, module_pin_out}, {7'h00, (k == 2) ? last : ~last});
    end
    wr(ccu_pkg::OFS_MODE_SELECT, 8'h00);
    wr(ccu_pkg::OFS_UNIT_STATUS, 8'h00);
    endt("toggle output");
    wr(ccu_pkg::OFS_MODE_SELECT, 8'h42);
    wr(ccu_pkg::OFS_COMPARE_LOW, 8'h80);
    wr(ccu_pkg::OFS_COMPARE_HIGH, 8'h40);
    tick({p[15:8], 8'h7f});
    check({7'h00, module_pin_out}, 8'h00);
    tick({p[15:8], 8'h80});
    check({7'h00, module_pin_out}, 8'h01);
    tick({p[15:8] + 8'h01, 8'h00});
    rd(ccu_pkg::OFS_COMPARE_LOW, 8'h40, 8'hff);
    tick({p[15:8], 8'h3f});
    check({7'h00, module_pin_out}, 8'h00);
    tick({p[15:8], 8'h40});
    check({7'h00, module_pin_out}, 8'h01);
    endt("pwm");
    wr(ccu_pkg::OFS_MODE_SELECT, 8'h00);
    p = 16'($urandom);
    wr(ccu_pkg::OFS_COMPARE_LOW, p[7:0]);
    wr(ccu_pkg::OFS_COMPARE_HIGH, p[15:8]);
    wr(ccu_pkg::OFS_MODE_SELECT, 8'h48);
    watchdog_arm_bit <= 1'b1;
    last = module_pin_out;
    tick(p);
    check({7'h00, watchdog_reset}, 8'h01);
    check({7'h00, module_pin_out}, {7'h00, last});
    @(posedge clk);
    #1;
    check({7'h00, watchdog_reset}, 8'h00);
    watchdog_arm_bit <= 1'b0;
    tick(p);
    check({7'h00, watchdog_reset}, 8'h00);
    watchdog_arm_bit <= 1'b1;
    tick(p);
    check({7'h00, watchdog_reset}, 8'h01);
    wr(ccu_pkg::OFS_COMPARE_HIGH, p[15:8] + 8'h80);
    tick(p);
    check({7'h00, watchdog_reset}, 8'h00);
    check({7'h00, wd_plain_seen}, 8'h00);
    endt("watchdog");
    idle(4);
    check(8'(exp_q.size()), 8'h00);
    results;
  end
endmodule
